// File: um_serial.sv
// Serial port: mode 0 synchronous receive and mode 1 ten-bit frames
`timescale 1ns/1ps
`default_nettype none
`include "um_defs.svh"
module um_serial
   import um_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic rxd,
   output logic txd,
   output logic irq
);

   um_st_t s_q;
   um_st_t s_d;
   logic [1:0] rst_sync_q;
   um_bus_req_t bus;

   // Prescaler limit per clock select code
   function automatic logic [2:0] pre_limit(input logic [1:0] sel);
      unique case (sel)
         2'h0: pre_limit = 3'h7;
         2'h1: pre_limit = 3'h3;
         2'h2: pre_limit = 3'h1;
         2'h3: pre_limit = 3'h0;
      endcase
   endfunction

   // Write-one-to-clear with the hardware set winning
   function automatic logic [7:0] w1c(input logic [7:0] q, input logic [7:0] clr,
                                      input logic [7:0] set);
      w1c = (q & ~clr) | set;
   endfunction

   assign bus.addr = addr;
   assign bus.wdata = wdata;
   assign bus.wr = wr;
   assign bus.rd = rd;

   // Reset released through two flops so every state flop leaves reset together
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   always_comb begin
      logic tick_u;
      logic tick16;
      logic rx_bit_in;
      logic [7:0] req_set;
      logic [7:0] flag_set;
      logic [7:0] req_clr;
      logic [7:0] flag_clr;
      logic [7:0] nxt_req;
      logic [7:0] nxt_flag;
      logic hw_rx_en_clr;
      logic m0_clk;
      s_d = s_q;
      tick_u = 1'b0;
      tick16 = 1'b0;
      rx_bit_in = s_q.rxd_s[1];
      req_set = 8'h00;
      flag_set = 8'h00;
      req_clr = 8'h00;
      flag_clr = 8'h00;
      hw_rx_en_clr = 1'b0;
      m0_clk = 1'b1;
      nxt_req = 8'h00;
      nxt_flag = 8'h00;

      // Pin passes two flops before anyone looks at it
      s_d.rxd_s = {s_q.rxd_s[0], rxd};

      // Port clock from the clock select divider
      if (s_q.pre_cnt >= pre_limit(s_q.clk_sel)) begin
         s_d.pre_cnt = 3'h0;
         tick_u = 1'b1;
      end else begin
         s_d.pre_cnt = s_q.pre_cnt + 3'h1;
      end

      // Oversample tick every divisor plus one port clocks
      if (tick_u) begin
         if (s_q.baud_cnt >= s_q.baud) begin
            s_d.baud_cnt = 8'h00;
            tick16 = 1'b1;
         end else begin
            s_d.baud_cnt = s_q.baud_cnt + 8'h01;
         end
      end

      // Transmitter: plain ten-bit frame, never a parity slot
      unique case (s_q.tx_st)
         UM_TX_IDLE: begin
            if (bus.wr && bus.addr == `UM_OFS_DATA && s_q.mode == UM_MODE_ASYNC8) begin
               s_d.tx_sh = {1'b1, bus.wdata, 1'b0};
               // Line stays idle until the next tick, so the start bit is a whole bit
               s_d.tx_bit = `UM_TX_WAIT;
               s_d.tx_ph = `UM_OVS_LAST;
               s_d.tx_st = UM_TX_SHIFT;
            end
         end
         UM_TX_SHIFT: begin
            if (tick16) begin
               s_d.tx_ph = s_q.tx_ph + 4'h1;
               if (s_q.tx_ph == `UM_OVS_LAST) begin
                  s_d.tx_bit = s_q.tx_bit + 4'h1;
                  // The wait slot only lines the frame up with a tick; nothing shifts
                  if (s_q.tx_bit != `UM_TX_WAIT) begin
                     s_d.tx_sh = {1'b1, s_q.tx_sh[9:1]};
                  end
                  if (s_q.tx_bit == `UM_FRAME_LAST) begin
                     s_d.tx_st = UM_TX_IDLE;
                     req_set[`UM_BIT_TX_REQ] = 1'b1;
                     flag_set[`UM_BIT_TX_FLAG] = 1'b1;
                  end
               end
            end
         end
      endcase

      // Receiver: mode 0 shift clock master or mode 1 oversampled frame
      unique case (s_q.rx_st)
         UM_RX_IDLE: begin
            s_d.rx_ph = 4'h0;
            s_d.rx_bit = 4'h0;
            // Entering on a tick keeps the first low half as long as the others
            if (s_q.rx_en && s_q.mode == UM_MODE_SYNC && tick16) begin
               s_d.rx_st = UM_RX_SYNC;
            end else if (s_q.rx_en && s_q.mode == UM_MODE_ASYNC8 && !rx_bit_in) begin
               s_d.rx_st = UM_RX_START;
            end
         end
         UM_RX_SYNC: begin
            // Low first half; the data pin is sampled as the high half ends, at the falling edge
            m0_clk = s_q.rx_ph[3];
            if (tick16) begin
               s_d.rx_ph = s_q.rx_ph + 4'h1;
               if (s_q.rx_ph == `UM_OVS_LAST) begin
                  s_d.rx_sh = {rx_bit_in, s_q.rx_sh[7:1]};
                  s_d.rx_bit = s_q.rx_bit + 4'h1;
                  if (s_q.rx_bit == `UM_DATA_LAST) begin
                     s_d.rx_buf = {rx_bit_in, s_q.rx_sh[7:1]};
                     req_set[`UM_BIT_RX_REQ] = 1'b1;
                     flag_set[`UM_BIT_RX_FLAG] = 1'b1;
                     hw_rx_en_clr = 1'b1;
                     s_d.rx_st = UM_RX_IDLE;
                  end
               end
            end
         end
         UM_RX_START: begin
            if (tick16) begin
               s_d.rx_ph = s_q.rx_ph + 4'h1;
               if (s_q.rx_ph == `UM_OVS_HALF) begin
                  s_d.rx_ph = 4'h0;
                  // A glitch that is high again at mid start is dropped
                  s_d.rx_st = rx_bit_in ? UM_RX_IDLE : UM_RX_DATA;
               end
            end
         end
         UM_RX_DATA: begin
            if (tick16) begin
               s_d.rx_ph = s_q.rx_ph + 4'h1;
               if (s_q.rx_ph == `UM_OVS_LAST) begin
                  s_d.rx_sh = {rx_bit_in, s_q.rx_sh[7:1]};
                  s_d.rx_bit = s_q.rx_bit + 4'h1;
                  if (s_q.rx_bit == `UM_DATA_LAST) begin
                     s_d.rx_st = UM_RX_STOP;
                  end
               end
            end
         end
         UM_RX_STOP: begin
            if (tick16) begin
               s_d.rx_ph = s_q.rx_ph + 4'h1;
               if (s_q.rx_ph == `UM_OVS_LAST) begin
                  s_d.rx_st = UM_RX_IDLE;
                  // Framing error: byte is discarded, no request raised
                  if (rx_bit_in) begin
                     s_d.rx_buf = s_q.rx_sh;
                     req_set[`UM_BIT_RX_REQ] = 1'b1;
                  end
               end
            end
         end
         default: s_d.rx_st = UM_RX_IDLE;
      endcase

      // Transmit pin: mode 0 shift clock, else frame bit, idles high
      if (s_q.rx_st == UM_RX_SYNC) begin
         s_d.txd = m0_clk;
      end else if (s_q.tx_st == UM_TX_SHIFT && s_q.tx_bit != `UM_TX_WAIT) begin
         s_d.txd = s_q.tx_sh[0];
      end else begin
         s_d.txd = 1'b1;
      end

      // Register writes
      if (bus.wr) begin
         unique case (bus.addr)
            `UM_OFS_CTRL_HIGH: begin
               s_d.mode = um_mode_t'(bus.wdata[`UM_MODE_HI:`UM_MODE_LO]);
               s_d.rx_en = bus.wdata[`UM_BIT_RX_EN];
            end
            `UM_OFS_CTRL_LOW: s_d.clk_sel = bus.wdata[`UM_CSEL_HI:`UM_CSEL_LO];
            `UM_OFS_BAUD: s_d.baud = bus.wdata;
            `UM_OFS_IRQ_REQ: req_clr = bus.wdata;
            `UM_OFS_INT_FLAG: flag_clr = bus.wdata;
            `UM_OFS_IRQ_MASK: s_d.irq_mask = bus.wdata;
            default: begin
            end
         endcase
      end
      // Hardware end of a mode 0 byte closes receive enable
      if (hw_rx_en_clr) begin
         s_d.rx_en = 1'b0;
      end

      // Sticky status, set beats a simultaneous clear
      nxt_req = w1c(s_q.irq_req, req_clr, req_set);
      nxt_flag = w1c(s_q.int_flag, flag_clr, flag_set);
      s_d.irq_req = nxt_req;
      s_d.int_flag = nxt_flag;
      s_d.irq = |(nxt_req & s_q.irq_mask);

      // Read data stands only in the cycle after the strobe
      s_d.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            `UM_OFS_CTRL_HIGH: begin
               s_d.rdata[`UM_MODE_HI:`UM_MODE_LO] = s_q.mode;
               s_d.rdata[`UM_BIT_RX_EN] = s_q.rx_en;
            end
            `UM_OFS_CTRL_LOW: s_d.rdata[`UM_CSEL_HI:`UM_CSEL_LO] = s_q.clk_sel;
            `UM_OFS_BAUD: s_d.rdata = s_q.baud;
            `UM_OFS_DATA: s_d.rdata = s_q.rx_buf;
            `UM_OFS_IRQ_REQ: s_d.rdata = s_q.irq_req;
            `UM_OFS_INT_FLAG: s_d.rdata = s_q.int_flag;
            `UM_OFS_IRQ_MASK: s_d.rdata = s_q.irq_mask;
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   // State register; only the two flag bits of each status byte are live
   always_ff @(posedge clk or negedge rst_sync_q[1]) begin
      if (!rst_sync_q[1]) begin
         s_q <= '0;
         s_q.txd <= 1'b1;
         s_q.rxd_s <= 2'h3;
         s_q.rx_st <= UM_RX_IDLE;
         s_q.tx_st <= UM_TX_IDLE;
      end else begin
         s_q <= s_d;
         s_q.irq_req <= s_d.irq_req & 8'h18;
         s_q.int_flag <= s_d.int_flag & 8'h03;
      end
   end

   assign rdata = s_q.rdata;
   assign txd = s_q.txd;
   assign irq = s_q.irq;

endmodule
`default_nettype wire

// File: um_defs.svh
// Offsets, field positions, reset values and counter limits for the serial port
// Function
// - Mode 0 receive enable starts shift clock on transmit pin, samples receive pin
// - Mode 0 reception end sets rx request and rx flag bits
// - Mode 1 frame: start 0, eight data bits LSB first, stop 1
// - Mode 1 bit rate follows the baud divisor register
// - Mode 1 frames carry no parity bit
// - Mode 1 data write starts transmission; frame end sets tx request bit
// - Mode 1 receive starts on falling start bit; frame end sets rx request only if the stop bit is high
// - Mode field codes: 00 sync, 01 8-bit async, 10 and 11 9-bit; codes 10 and 11 are stored but neither send nor receive
// - Clock select: 00 div 8, 01 div 4, 10 div 2, 11 undivided
// - Bit rate is port clock over sixteen times divisor plus one
// - Mode 1 data writes load transmit buffer; reads return separate receive buffer
`ifndef UM_DEFS_SVH
`define UM_DEFS_SVH
`define UM_OFS_CTRL_HIGH 3'h0
`define UM_OFS_CTRL_LOW 3'h1
`define UM_OFS_BAUD 3'h2
`define UM_OFS_DATA 3'h3
`define UM_OFS_IRQ_REQ 3'h4
`define UM_OFS_INT_FLAG 3'h5
`define UM_OFS_IRQ_MASK 3'h6
`define UM_BIT_RX_EN 4
`define UM_MODE_HI 7
`define UM_MODE_LO 6
`define UM_CSEL_HI 3
`define UM_CSEL_LO 2
`define UM_BIT_TX_REQ 3
`define UM_BIT_RX_REQ 4
`define UM_BIT_TX_FLAG 0
`define UM_BIT_RX_FLAG 1
`define UM_RST_REG 8'h00
`define UM_OVS_LAST 4'hf
`define UM_OVS_HALF 4'h7
`define UM_DATA_LAST 4'h7
`define UM_FRAME_LAST 4'h9
`define UM_TX_WAIT 4'hf
`endif

// File: um_pkg.sv
// Types for the serial port: modes, state machines and the state record
package um_pkg;
   typedef enum logic [1:0] {
      UM_MODE_SYNC = 2'h0,
      UM_MODE_ASYNC8 = 2'h1,
      UM_MODE_FIX9 = 2'h2,
      UM_MODE_VAR9 = 2'h3
   } um_mode_t;
   typedef enum logic [2:0] {
      UM_RX_IDLE, UM_RX_SYNC, UM_RX_START, UM_RX_DATA, UM_RX_STOP
   } um_rx_st_t;
   typedef enum logic {UM_TX_IDLE, UM_TX_SHIFT} um_tx_st_t;
   typedef struct packed {
      um_mode_t mode;
      logic rx_en;
      logic [1:0] clk_sel;
      logic [7:0] baud;
      logic [7:0] rx_buf;
      logic [7:0] irq_req;
      logic [7:0] int_flag;
      logic [7:0] irq_mask;
      logic [7:0] rdata;
      logic txd;
      logic irq;
      logic [1:0] rxd_s;
      logic [2:0] pre_cnt;
      logic [7:0] baud_cnt;
      um_tx_st_t tx_st;
      logic [9:0] tx_sh;
      logic [3:0] tx_bit;
      logic [3:0] tx_ph;
      um_rx_st_t rx_st;
      logic [7:0] rx_sh;
      logic [3:0] rx_bit;
      logic [3:0] rx_ph;
   } um_st_t;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } um_bus_req_t;
endpackage

// File: um_serial_sva.sv
// Port checker for the serial port, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module um_serial_sva
   import um_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic rxd,
   input wire logic txd,
   input wire logic irq
);
   logic [7:0] ctl_q, csel_q, baud_q, mask_q;
   logic [15:0] run_q;
   logic [3:0] falls_q;
   logic txd_q;
   int t;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Oversample period from shadowed setup; the shadows ignore hardware clears
   assign t = (8 >> csel_q[3:2]) * (baud_q + 1);
   // Shadow software writes; run_q holds how long txd has kept its level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl_q <= 8'h00;
         csel_q <= 8'h00;
         baud_q <= 8'h00;
         mask_q <= 8'h00;
         run_q <= 16'h0000;
         falls_q <= 4'h0;
         txd_q <= 1'b1;
      end else begin
         if (wr && addr == 3'h0) ctl_q <= wdata;
         if (wr && addr == 3'h1) csel_q <= wdata;
         if (wr && addr == 3'h2) baud_q <= wdata;
         if (wr && addr == 3'h6) mask_q <= wdata;
         run_q <= (txd != txd_q) ? 16'h0001 : run_q + 16'h0001;
         txd_q <= txd;
         if (wr && addr == 3'h0) falls_q <= 4'h0;
         else if (txd_q && !txd && ctl_q[7:6] == 2'h0) falls_q <= falls_q + 4'h1;
      end
   end
   property p_unmapped;
      rd && addr == 3'h7 |=> rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ctl_bits;
      rd && addr == 3'h0 |=> (rdata & 8'h2f) == 8'h00 && rdata[7:6] == ctl_q[7:6];
   endproperty
   a_ctl_bits: assert property (p_ctl_bits) else $error("mode field readback wrong");
   property p_m1_bits;
      ctl_q[7:6] == 2'h1 && $rose(txd) |-> run_q != 0 && run_q % (16 * t) == 0;
   endproperty
   a_m1_bits: assert property (p_m1_bits) else $error("low run not whole bits");
   property p_m0_low;
      ctl_q[7:6] == 2'h0 && $rose(txd) |-> run_q == 8 * t;
   endproperty
   a_m0_low: assert property (p_m0_low) else $error("shift clock low half wrong");
   property p_m0_stop;
      ctl_q[7:6] == 2'h0 |-> falls_q <= 4'h8;
   endproperty
   a_m0_stop: assert property (p_m0_stop) else $error("shift clock ran past eight");
   property p_m0_start;
      wr && addr == 3'h0 && wdata == 8'h10 && t <= 8 |-> ##[1:100] !txd;
   endproperty
   a_m0_start: assert property (p_m0_start) else $error("shift clock did not start");
   property p_m1_tx;
      wr && addr == 3'h3 && ctl_q[7:6] == 2'h1 && t <= 8 |-> ##[1:140] !txd;
   endproperty
   a_m1_tx: assert property (p_m1_tx) else $error("no start bit after data write");
   property p_irq;
      irq |-> $past(mask_q) != 8'h00;
   endproperty
   a_irq: assert property (p_irq) else $error("irq with all sources masked");
   c_m0: cover property (ctl_q[7:6] == 2'h0 && $rose(txd));
   c_m1: cover property (ctl_q[7:6] == 2'h1 && $rose(txd));
   c_irq: cover property ($rose(irq));
endmodule
bind um_serial um_serial_sva u_um_serial_sva (.clk(clk), .rstn(rstn), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq));
`default_nettype wire

// File: um_peer.sv
// Remote serial peer on the line side of the port
`timescale 1ns/1ps
`default_nettype none
module um_peer (
   input wire logic clk,
   input wire logic txd,
   output var logic rxd
);
   // Line idles high, as with a pull-up
   initial rxd = 1'b1;
   // One frame: start 0, data LSB first, then the stop level asked
   task automatic send(input logic [7:0] b, input int bc, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk) rxd <= f[i];
         repeat (bc - 1) @(posedge clk);
      end
      @(posedge clk) rxd <= 1'b1;
   endtask
   // Samples ten bits at their centres, start bit included
   task automatic get(input int bc, output logic [9:0] f);
      while (txd !== 1'b0) @(posedge clk);
      repeat (bc / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         f[i] = txd;
         repeat (bc) @(posedge clk);
      end
   endtask
   // New bit after each falling shift clock, so it is steady well before sampling
   task automatic sync(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(negedge txd);
         @(posedge clk) rxd <= b[i];
      end
      @(posedge txd);
      repeat (40) @(posedge clk);
      rxd <= 1'b1;
   endtask
endmodule
`default_nettype wire

// File: tb_um_serial.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module tb_um_serial;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic rxd, txd, irq;
   int mismatches = 0;
   int num_checks = 0;
   always #50 clk = ~clk;
   um_serial u_um_serial (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq));
   um_peer u_um_peer (.clk(clk), .txd(txd), .rxd(rxd));
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // Bus cycles; the trailing delay lets the edge's updates land before sampling
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(n, {2'b00, e}, {2'b00, rdata});
   endtask
   task automatic wirq();
      for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk);
      #1;
   endtask
   task automatic t_regs();
      for (int i = 0; i < 8; i++) rchk("reset", i[2:0], 8'h00);
      wreg(3'h0, 8'hff);
      rchk("ctrl", 3'h0, 8'hd0);
      wreg(3'h7, 8'hff);
      rchk("unmapped", 3'h7, 8'h00);
      wreg(3'h0, 8'h00);
   endtask
   task automatic t_m0();
      wreg(3'h1, 8'h0c);
      wreg(3'h2, 8'h01);
      wreg(3'h4, 8'h10);
      wreg(3'h6, 8'h10);
      fork
         u_um_peer.sync(8'ha5);
         begin
            wreg(3'h0, 8'h10);
            wirq();
         end
      join
      chk("m0 irq", 10'h1, {9'h0, irq});
      rchk("m0 data", 3'h3, 8'ha5);
      rchk("m0 req", 3'h4, 8'h10);
      rchk("m0 flag", 3'h5, 8'h02);
      rchk("m0 ctrl", 3'h0, 8'h00);
      chk("m0 txd", 10'h1, {9'h0, txd});
      wreg(3'h4, 8'h10);
      wreg(3'h5, 8'h02);
      chk("irq clear", 10'h0, {9'h0, irq});
      wreg(3'h6, 8'h00);
   endtask
   // Mode 1 transmit; the mask stays clear, so irq must not follow the request
   task automatic t_tx(input logic [1:0] c, input logic [7:0] bd, input logic [7:0] b);
      logic [9:0] f;
      int bc;
      bc = 16 * (8 >> c) * (bd + 1);
      wreg(3'h1, {4'h0, c, 2'b00});
      wreg(3'h2, bd);
      wreg(3'h0, 8'h40);
      rchk("clock sel", 3'h1, {4'h0, c, 2'b00});
      rchk("baud", 3'h2, bd);
      fork
         u_um_peer.get(bc, f);
         wreg(3'h3, b);
      join
      chk("tx frame", {1'b1, b, 1'b0}, f);
      rchk("tx req", 3'h4, 8'h08);
      chk("tx masked", 10'h0, {9'h0, irq});
      rchk("tx flag", 3'h5, 8'h01);
      wreg(3'h4, 8'h08);
      wreg(3'h5, 8'h01);
   endtask
   // Mode 1 receive; a start pulse shorter than half a bit must be ignored
   task automatic t_rx();
      wreg(3'h1, 8'h0c);
      wreg(3'h2, 8'h01);
      wreg(3'h6, 8'h10);
      wreg(3'h0, 8'h50);
      rchk("mask", 3'h6, 8'h10);
      u_um_peer.send(8'h3c, 32, 1'b1);
      wirq();
      chk("rx irq", 10'h1, {9'h0, irq});
      rchk("rx data", 3'h3, 8'h3c);
      rchk("rx flag", 3'h5, 8'h00);
      wreg(3'h4, 8'h10);
      u_um_peer.send(8'hff, 4, 1'b1);
      repeat (100) @(posedge clk);
      rchk("glitch", 3'h4, 8'h00);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Reset for three cycles, settle, then run every scenario
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      t_regs();
      t_m0();
      for (int c = 0; c < 4; c++) t_tx(c[1:0], c[7:0], 8'h55 + c[7:0]);
      t_rx();
      report_and_stop();
   end
   // The run needs about 6000 cycles; five times that means a hang
   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
endmodule
`default_nettype wire
